// file: emii_port.sv
// External MII port: transmit launch, receive capture, management pin steering
`timescale 1ns/1ps
module emii_port
	import emii_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic EXT_PHY_SEL,
	input wire logic MGMT_PORT_SELECT,
	input wire emii_tx_t MAC_TX,
	output logic MAC_TX_TAKE,
	output emii_rx_t MAC_RX,
	output logic MAC_RX_STB,
	input wire logic MAC_MDC,
	input wire logic MAC_MDIO_O,
	input wire logic MAC_MDIO_OE,
	output logic MAC_MDIO_I,
	output logic EXTERNAL_PHY_STRAP,
	input wire logic TX_CLK_PIN,
	output logic [3:0] TXD_PIN,
	output logic TX_EN_PIN,
	input wire logic RX_CLK_PIN,
	input wire emii_rx_t RX_PIN,
	output logic MDC_PIN,
	input wire logic MDIO_I_PIN,
	output logic MDIO_O_PIN,
	output logic MDIO_OE_PIN
);
	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every pin input; stage one feeds only stage two
	logic txc_s1_q, txc_s2_q, txc_s3_q;
	logic rxc_s1_q, rxc_s2_q, rxc_s3_q;
	emii_rx_t rx_s1_q, rx_s2_q;
	logic mdio_s1_q, mdio_s2_q;
	always_ff @(posedge CLK) begin
		if (SRST) begin
			txc_s1_q <= 1'b0;
			txc_s2_q <= 1'b0;
			txc_s3_q <= 1'b0;
			rxc_s1_q <= 1'b0;
			rxc_s2_q <= 1'b0;
			rxc_s3_q <= 1'b0;
			rx_s1_q <= '0;
			rx_s2_q <= '0;
			mdio_s1_q <= 1'b0;
			mdio_s2_q <= 1'b0;
		end else if (CE) begin
			txc_s1_q <= TX_CLK_PIN;
			txc_s2_q <= txc_s1_q;
			txc_s3_q <= txc_s2_q;
			rxc_s1_q <= RX_CLK_PIN;
			rxc_s2_q <= rxc_s1_q;
			rxc_s3_q <= rxc_s2_q;
			rx_s1_q <= RX_PIN;
			rx_s2_q <= rx_s1_q;
			mdio_s1_q <= MDIO_I_PIN;
			mdio_s2_q <= mdio_s1_q;
		end
	end

	// Limitation: a link clock must stay well below a third of CLK, or rises are lost
	// Data and clocks pass the same flops, so each nibble lines up with its own edge
	// Edge detection on synchronised link clocks; data group lags by the same two flops
	logic tx_rise, rx_rise;
	assign tx_rise = txc_s2_q & ~txc_s3_q;
	assign rx_rise = rxc_s2_q & ~rxc_s3_q;

	////////////////////////////////////////////////////////////////////////////
	// Transmit launch: PHY samples on its rising edge, so we update right after it
	always_ff @(posedge CLK) begin
		if (SRST) begin
			TXD_PIN <= EMII_TXD_RST;
			TX_EN_PIN <= EMII_TXEN_RST;
			MAC_TX_TAKE <= 1'b0;
		end else if (CE) begin
			MAC_TX_TAKE <= 1'b0;
			if (!EXT_PHY_SEL) begin
				TXD_PIN <= EMII_TXD_RST;
				TX_EN_PIN <= 1'b0;
			end else if (tx_rise) begin
				TXD_PIN <= MAC_TX.en ? MAC_TX.d : EMII_TXD_RST;
				TX_EN_PIN <= MAC_TX.en;
				MAC_TX_TAKE <= MAC_TX.en;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive capture on RX clock rising edge, col and crs followed every cycle between edges; idle when internal PHY in use
	always_ff @(posedge CLK) begin
		if (SRST) begin
			MAC_RX <= '0;
			MAC_RX_STB <= 1'b0;
		end else if (CE) begin
			MAC_RX_STB <= 1'b0;
			if (!EXT_PHY_SEL) begin
				MAC_RX <= '0;
			end else if (rx_rise) begin
				MAC_RX <= rx_s2_q;
				MAC_RX_STB <= rx_s2_q.dv;
			end else begin
				MAC_RX.col <= rx_s2_q.col;
				MAC_RX.crs <= rx_s2_q.crs;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Management pins: MAC drives only when the external port is selected
	// The returned bit is gated so a floating pin cannot reach the MAC when deselected
	always_ff @(posedge CLK) begin
		if (SRST) begin
			MDC_PIN <= EMII_MDC_RST;
			MDIO_O_PIN <= 1'b0;
			MDIO_OE_PIN <= 1'b0;
			MAC_MDIO_I <= 1'b0;
		end else if (CE) begin
			MDC_PIN <= MGMT_PORT_SELECT ? MAC_MDC : 1'b0;
			MDIO_O_PIN <= MGMT_PORT_SELECT & MAC_MDIO_O;
			MDIO_OE_PIN <= MGMT_PORT_SELECT & MAC_MDIO_OE;
			MAC_MDIO_I <= MGMT_PORT_SELECT & mdio_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap capture: sampled once after reset release; MDIO output enable is not held off until then
	// Waiting a few cycles lets the synchroniser flush its reset zeros first
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	always_ff @(posedge CLK) begin
		if (SRST) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			EXTERNAL_PHY_STRAP <= 1'b0;
		end else if (CE && !strap_done_q) begin
			if (strap_cnt_q == EMII_STRAP_DLY) begin
				EXTERNAL_PHY_STRAP <= mdio_s2_q;
				strap_done_q <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_txd_internal: assert property (@(posedge CLK) disable iff (SRST)
		CE && !EXT_PHY_SEL |=> TXD_PIN == 4'h0)
		else $error("TXD not low with internal PHY");
	a_txen_internal: assert property (@(posedge CLK) disable iff (SRST)
		CE && !EXT_PHY_SEL |=> !TX_EN_PIN)
		else $error("TX enable not low with internal PHY");
	a_txen_valid: assert property (@(posedge CLK) disable iff (SRST)
		!TX_EN_PIN |-> TXD_PIN == 4'h0)
		else $error("TXD active without TX enable");
	a_tx_on_edge: assert property (@(posedge CLK) disable iff (SRST)
		CE && EXT_PHY_SEL && tx_rise |=> TX_EN_PIN == $past(MAC_TX.en))
		else $error("TX enable not launched on TX clock edge");
	a_tx_hold: assert property (@(posedge CLK) disable iff (SRST)
		CE && EXT_PHY_SEL && $past(EXT_PHY_SEL) && !tx_rise |=> $stable(TXD_PIN))
		else $error("TXD changed between TX clock edges");
	a_rx_capture: assert property (@(posedge CLK) disable iff (SRST)
		CE && EXT_PHY_SEL && rx_rise |=> MAC_RX_STB == $past(rx_s2_q.dv))
		else $error("Receive strobe does not follow valid");
	a_rx_err: assert property (@(posedge CLK) disable iff (SRST)
		CE && EXT_PHY_SEL && rx_rise |=> MAC_RX.er == $past(rx_s2_q.er))
		else $error("Receive error not captured");
	a_mdc_low: assert property (@(posedge CLK) disable iff (SRST)
		CE && !MGMT_PORT_SELECT |=> !MDC_PIN)
		else $error("MDC not low when port deselected");
	a_mdio_tri: assert property (@(posedge CLK) disable iff (SRST)
		CE && !MGMT_PORT_SELECT |=> !MDIO_OE_PIN)
		else $error("MDIO driven when port deselected");
	a_mdio_drive: assert property (@(posedge CLK) disable iff (SRST)
		CE && MGMT_PORT_SELECT && MAC_MDIO_OE |=> MDIO_OE_PIN && MDIO_O_PIN == $past(MAC_MDIO_O))
		else $error("MDIO not driven from MAC");
	a_strap_once: assert property (@(posedge CLK) disable iff (SRST)
		strap_done_q && $past(strap_done_q) |-> $stable(EXTERNAL_PHY_STRAP))
		else $error("Strap changed after capture");
	// Routing, freeze and strap capture checks
	a_take_internal: assert property (@(posedge CLK) disable iff (SRST)
		CE && !EXT_PHY_SEL |=> !MAC_TX_TAKE)
		else $error("Nibble taken with internal PHY");
	a_rx_internal: assert property (@(posedge CLK) disable iff (SRST)
		CE && !EXT_PHY_SEL |=> MAC_RX == '0 && !MAC_RX_STB)
		else $error("Receive group not idle with internal PHY");
	a_rx_quiet: assert property (@(posedge CLK) disable iff (SRST)
		CE && !rx_s2_q.dv |=> !MAC_RX_STB)
		else $error("Receive strobe without valid");
	a_mdc_follow: assert property (@(posedge CLK) disable iff (SRST)
		CE && MGMT_PORT_SELECT |=> MDC_PIN == $past(MAC_MDC))
		else $error("MDC does not follow the MAC clock");
	a_strap_take: assert property (@(posedge CLK) disable iff (SRST)
		CE && !strap_done_q && strap_cnt_q == EMII_STRAP_DLY
		|=> EXTERNAL_PHY_STRAP == $past(mdio_s2_q))
		else $error("Strap not taken from the synchronised pin");
	a_ce_freeze: assert property (@(posedge CLK) disable iff (SRST)
		!CE |=> $stable(TXD_PIN) && $stable(TX_EN_PIN) && $stable(MAC_RX) && $stable(MDC_PIN))
		else $error("State moved while clock enable low");

	c_tx_nibble: cover property (@(posedge CLK) disable iff (SRST) TX_EN_PIN && TXD_PIN != 4'h0);
	c_rx_frame: cover property (@(posedge CLK) disable iff (SRST) MAC_RX_STB ##[1:60] MAC_RX_STB);
	c_rx_err: cover property (@(posedge CLK) disable iff (SRST) MAC_RX_STB && MAC_RX.er);
	c_mdio: cover property (@(posedge CLK) disable iff (SRST) MDIO_OE_PIN && MDC_PIN);
	c_strap: cover property (@(posedge CLK) disable iff (SRST) $rose(strap_done_q));
endmodule

// file: emii_pkg.sv
// Package for the external MII port: constants and carrier types
package emii_pkg;
	// Nibble width of the media independent interface
	localparam int EMII_NIB_W = 4;
	// Reset values of the pin outputs
	localparam logic [3:0] EMII_TXD_RST = 4'h0;
	localparam logic EMII_TXEN_RST = 1'b0;
	localparam logic EMII_MDC_RST = 1'b0;
	// Strap is caught on the cycle after the count reaches this value from reset release (after sync)
	localparam logic [1:0] EMII_STRAP_DLY = 2'h3;

	// Transmit nibble plus enable, from MAC or toward pins
	typedef struct packed {
		logic en;
		logic [3:0] d;
	} emii_tx_t;

	// Receive group from the PHY
	typedef struct packed {
		logic dv;
		logic er;
		logic col;
		logic crs;
		logic [3:0] d;
	} emii_rx_t;
endpackage

// file: emii_phy_model.sv
// Behavioural external PHY: free MII clocks, receive pins, MDIO pin level
`timescale 1ns/1ps
module emii_phy_model
	import emii_pkg::*;
(
	input wire emii_rx_t rx_next,
	input wire logic strap,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	output logic tx_clk,
	output logic rx_clk,
	output emii_rx_t rx_pin,
	output logic mdio_pin
);
	logic tx_q = 1'b0;
	logic rx_q = 1'b0;
	emii_rx_t rx_grp_q = '0;
	// MII clocks run free with an 800 ns period; edges never meet a bench clock edge
	initial begin
		#130;
		forever #400 tx_q = ~tx_q;
	end
	initial begin
		#270;
		forever #400 rx_q = ~rx_q;
	end
	// Receive group moves on the falling edge so it is settled at the rise
	always @(negedge rx_q) begin
		rx_grp_q <= rx_next;
	end
	assign tx_clk = tx_q;
	assign rx_clk = rx_q;
	assign rx_pin = rx_grp_q;
	// A released pin shows the board strap level, never the last driven bit
	assign mdio_pin = mdio_oe ? mdio_o : strap;
endmodule

// file: tb.sv
// Self-checking bench for the external MII port
`timescale 1ns/1ps
module tb;
	import emii_pkg::*;
	int fail_count = 0;
	int n_compared = 0;
	int i;
	logic CLK = 1'b0, SRST = 1'b1, CE = 1'b1, EXT_PHY_SEL = 1'b0, MGMT_PORT_SELECT = 1'b0;
	logic MAC_MDC = 1'b0, MAC_MDIO_O = 1'b0, MAC_MDIO_OE = 1'b0, strap = 1'b0;
	emii_tx_t MAC_TX = '0;
	emii_rx_t MAC_RX, RX_PIN, rx_next = '0;
	logic MAC_TX_TAKE, MAC_RX_STB, MAC_MDIO_I, EXTERNAL_PHY_STRAP, TX_CLK_PIN, RX_CLK_PIN;
	logic [3:0] TXD_PIN;
	logic TX_EN_PIN, MDC_PIN, MDIO_I_PIN, MDIO_O_PIN, MDIO_OE_PIN;
	always #50 CLK = ~CLK;
	emii_port emii_port_inst (.CLK, .SRST, .CE, .EXT_PHY_SEL, .MGMT_PORT_SELECT, .MAC_TX,
		.MAC_TX_TAKE, .MAC_RX, .MAC_RX_STB, .MAC_MDC, .MAC_MDIO_O, .MAC_MDIO_OE, .MAC_MDIO_I,
		.EXTERNAL_PHY_STRAP, .TX_CLK_PIN, .TXD_PIN, .TX_EN_PIN, .RX_CLK_PIN, .RX_PIN,
		.MDC_PIN, .MDIO_I_PIN, .MDIO_O_PIN, .MDIO_OE_PIN);
	emii_phy_model emii_phy_model_inst (.rx_next, .strap, .mdio_o(MDIO_O_PIN),
		.mdio_oe(MDIO_OE_PIN), .tx_clk(TX_CLK_PIN), .rx_clk(RX_CLK_PIN), .rx_pin(RX_PIN),
		.mdio_pin(MDIO_I_PIN));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Bounded wait for a take or strobe pulse; a lost pulse ends the run
	task wait_pulse(input bit rx);
		for (i = 0; i < 40; i++) begin
			@(negedge CLK);
			if (rx ? MAC_RX_STB === 1'b1 : MAC_TX_TAKE === 1'b1) return;
		end
		fail_count++;
		results;
	endtask
	// Bounded wait for a falling receive clock, seen by sampling at the bench edge
	task wait_rx_fall;
		logic prev;
		prev = RX_CLK_PIN;
		for (i = 0; i < 20; i++) begin
			@(negedge CLK);
			if (prev === 1'b1 && RX_CLK_PIN === 1'b0) return;
			prev = RX_CLK_PIN;
		end
		fail_count++;
		results;
	endtask
	// Pins carry the nibble only for an enabled nibble on the external path
	function automatic logic [4:0] tx_exp(input logic sel, input emii_tx_t t);
		return (sel && t.en) ? {1'b1, t.d} : 5'h00;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(38601));
		strap = 1'($urandom);
		repeat (2) @(negedge CLK);
		SRST = 1'b0;
		repeat (8) @(negedge CLK);
		chk("strap", EXTERNAL_PHY_STRAP, strap);
		// Back-to-back nibbles, then idle, then internal PHY with MAC still asking
		EXT_PHY_SEL = 1'b1;
		for (int n = 0; n < 7; n++) begin
			MAC_TX = {1'b1, n == 0 ? 4'hF : 4'($urandom)};
			wait_pulse(1'b0);
			chk("tx pins", {TX_EN_PIN, TXD_PIN}, tx_exp(EXT_PHY_SEL, MAC_TX));
		end
		MAC_TX.en = 1'b0;
		repeat (12) @(negedge CLK);
		chk("tx idle", {TX_EN_PIN, TXD_PIN}, tx_exp(EXT_PHY_SEL, MAC_TX));
		MAC_TX.en = 1'b1;
		EXT_PHY_SEL = 1'b0;
		repeat (12) @(negedge CLK);
		chk("tx internal", {TX_EN_PIN, TXD_PIN, MAC_TX_TAKE}, {tx_exp(1'b0, MAC_TX), 1'b0});
		// Receive nibbles with random error flag
		EXT_PHY_SEL = 1'b1;
		for (int n = 0; n < 7; n++) begin
			rx_next = {1'b1, 1'($urandom), 2'b00, n == 0 ? 4'h0 : 4'($urandom)};
			wait_rx_fall;
			wait_pulse(1'b1);
			chk("rx group", MAC_RX, rx_next);
		end
		// Collision and carrier outside a frame, then internal PHY blanks the group
		rx_next = 8'h37;
		wait_rx_fall;
		repeat (4) @(negedge CLK);
		chk("col crs", {MAC_RX.col, MAC_RX.crs}, 2'b11);
		repeat (4) @(negedge CLK);
		chk("rx group no valid", MAC_RX, 8'h37);
		EXT_PHY_SEL = 1'b0;
		repeat (12) @(negedge CLK);
		chk("rx internal", MAC_RX, 8'h00);
		// Management pins follow the MAC only while the port is selected
		for (int s = 0; s < 2; s++) begin
			MGMT_PORT_SELECT = s[0];
			MAC_MDC = 1'b1;
			MAC_MDIO_OE = 1'b1;
			MAC_MDIO_O = 1'($urandom);
			repeat (5) @(negedge CLK);
			chk("mgmt pins", {MDC_PIN, MDIO_OE_PIN, MDIO_O_PIN & MDIO_OE_PIN},
				{3{s[0]}} & {2'b11, MAC_MDIO_O});
			chk("mdio in", MAC_MDIO_I, s[0] & MAC_MDIO_O);
		end
		// Clock enable low freezes the pins, then they follow the MAC again
		CE = 1'b0;
		MAC_MDC = 1'b0;
		repeat (5) @(negedge CLK);
		chk("mdc frozen", MDC_PIN, 1'b1);
		CE = 1'b1;
		repeat (5) @(negedge CLK);
		chk("mdc follow", MDC_PIN, 1'b0);
		// Second reset in mid-run with the opposite strap; port released at the same edge
		MAC_MDC = 1'b1;
		strap = ~strap;
		SRST = 1'b1;
		repeat (2) @(negedge CLK);
		chk("reset pins", {MDC_PIN, MDIO_OE_PIN, TX_EN_PIN, TXD_PIN}, 7'h00);
		SRST = 1'b0;
		MGMT_PORT_SELECT = 1'b0;
		repeat (8) @(negedge CLK);
		chk("strap again", EXTERNAL_PHY_STRAP, strap);
		results;
	end
endmodule
